/* shared/stc_pkg.sv */
`default_nettype none
package stc_pkg;

   // ==========================================================
   // widths
   localparam int ADDR_W     = 18;
   localparam int DATA_W     = 8;
   localparam int CREDIT_W   = 10;
   localparam int STATUS_W   = 2;
   localparam int PORT_W     = 8;
   localparam int MEM_ADDR_W = 9;
   localparam int NUM_BANKS  = 4;
   localparam int LEN_HI_W   = 2;
   localparam int LEN_W      = 10;
   localparam int LINE_BITS  = 128;

   // ==========================================================
   // register offsets
   localparam logic [17:0] OFS_CAL_CTRL    = 18'h30916;
   localparam logic [17:0] OFS_MEM_SEL     = 18'h30917;
   localparam logic [17:0] OFS_LEVEL_SEL   = 18'h30920;
   localparam logic [17:0] OFS_MAIN_REPEAT = 18'h30921;
   localparam logic [17:0] OFS_MAIN_LEN_HI = 18'h30922;
   localparam logic [17:0] OFS_MAIN_LEN_LO = 18'h30923;
   localparam logic [17:0] OFS_SHD_REPEAT  = 18'h30924;
   localparam logic [17:0] OFS_SHD_LEN_HI  = 18'h30925;
   localparam logic [17:0] OFS_SHD_LEN_LO  = 18'h30926;
   localparam logic [17:0] OFS_NUMFIFO     = 18'h30927;
   localparam logic [17:0] OFS_AGGR        = 18'h30930;

   // ==========================================================
   // field positions (bit 0 = lsb of the byte)
   localparam int BIT_CRED_SEL   = 1;
   localparam int BIT_STAT_SEL   = 0;
   localparam int BIT_CAL_DETECT = 1;
   localparam int FULL_SEL_MSB   = 7;
   localparam int EMPTY_SEL_MSB  = 3;

   // ==========================================================
   // reset values and codes
   localparam logic [7:0] RST_BYTE        = 8'h00;
   localparam logic [1:0] CAL_WORD_MAIN   = 2'h1;
   localparam logic [1:0] CAL_WORD_SHADOW = 2'h2;
   localparam logic [1:0] AGGR_INVALID    = 2'h3;

   // two-bit field of a bank, bank 0 in the top pair
   function automatic logic [1:0] bank_pair(input logic [7:0] value, input int bank);
      bank_pair = value[7 - 2 * bank -: 2];
   endfunction

endpackage
`default_nettype wire

/* core/stc_level_calc.sv */
`timescale 1ns/10ps
`default_nettype none
module stc_level_calc #(
   parameter int BANK_LINES = 32,
   parameter int LEVEL_W    = $clog2(BANK_LINES) + 1
) (
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire logic [1:0]         fifo_count_code,
   input  wire logic               full_sel,
   input  wire logic               empty_sel,
   output logic      [LEVEL_W-1:0] full_level,
   output logic      [LEVEL_W-1:0] empty_level
);

   // ==========================================================
   // partition size in 128-bit lines
   wire logic [LEVEL_W-1:0] part_lines =
      LEVEL_W'(BANK_LINES >> fifo_count_code);
   wire logic [LEVEL_W-1:0] quarter    = part_lines >> 2;
   wire logic [LEVEL_W-1:0] three_q    = part_lines - quarter + LEVEL_W'(1);
   wire logic [LEVEL_W-1:0] one_q      = (quarter != '0) ? quarter - LEVEL_W'(1) : '0;
   wire logic [LEVEL_W-1:0] next_full  = full_sel ? three_q : part_lines;
   wire logic [LEVEL_W-1:0] next_empty = empty_sel ? one_q : '0;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         full_level  <= '0;
         empty_level <= '0;
      end
      else
      begin
         full_level  <= next_full;
         empty_level <= next_empty;
      end
   end

   full_lvl_a: assert property (@(posedge clock) disable iff (rst)
      !full_sel && $stable(fifo_count_code) |=>
         full_level == LEVEL_W'(BANK_LINES >> $past(fifo_count_code)))
      else $error("full level not whole partition");

   empty_lvl_a: assert property (@(posedge clock) disable iff (rst)
      !empty_sel |=> empty_level == '0)
      else $error("empty level not zero");

endmodule
`default_nettype wire

/* core/stc_cal_detect.sv */
`timescale 1ns/10ps
`default_nettype none
module stc_cal_detect (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       detect_enable,
   input  wire logic       sync_seen,
   input  wire logic       sym_valid,
   input  wire logic [1:0] sym,
   output logic            use_shadow
);

   typedef enum logic {STC_WAIT_SYNC, STC_EXPECT_WORD} stc_det_t;
   stc_det_t state;
   stc_det_t next_state;
   logic     next_shadow;

   // ==========================================================
   // word after the sync pattern picks the calendar
   always_comb
   begin
      next_state  = state;
      next_shadow = use_shadow;
      case (state)
         STC_WAIT_SYNC:
            if (sync_seen && detect_enable)
               next_state = STC_EXPECT_WORD;
         STC_EXPECT_WORD:
            if (sym_valid)
            begin
               next_state = STC_WAIT_SYNC;
               if (sym == stc_pkg::CAL_WORD_MAIN)
                  next_shadow = 1'b0;
               else if (sym == stc_pkg::CAL_WORD_SHADOW)
                  next_shadow = 1'b1;
            end
         default:
            next_state = STC_WAIT_SYNC;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state      <= STC_WAIT_SYNC;
         use_shadow <= 1'b0;
      end
      else
      begin
         state      <= next_state;
         use_shadow <= next_shadow;
      end
   end

   cal_switch_a: assert property (@(posedge clock) disable iff (rst)
      state == STC_EXPECT_WORD && sym_valid && sym == stc_pkg::CAL_WORD_SHADOW |=> use_shadow)
      else $error("shadow select word ignored");

endmodule
`default_nettype wire

/* core/stc_tx_config.sv */
// What this block does
// - credit memory, 512 byte addresses, 10-bit credits, reachable only with its select set
// - upper eight of nine address bits pick the port's credit
// - address bit 0 picks low credit byte or right-justified upper two bits
// - status memory 0..255 reachable with its select set and the credit select clear, two status bits right
// - per-bank full level: truly full, or three quarters of lines plus one
// - per-bank empty level: truly empty, or one quarter of lines minus one
// - every buffer line counts as 128 bits regardless of aggregation mode
// - eight-bit main calendar repeat count between framing patterns
// - main calendar length is 10 bits, two high bits then eight low bits
// - eight-bit shadow calendar repeat count between framing patterns
// - shadow calendar length, two high bits then eight low bits in next register
// - virtual fifo code 00,01,10,11 gives one, two, four, eight fifos
// - virtual fifo codes sit in bit pairs, bank 0 first
// - aggregation code selects 32, 64 or 128 bits; code 11 invalid
// - when enabled, calendar select word after frame sync switches main or shadow
`timescale 1ns/10ps
`default_nettype none
module stc_tx_config #(
   parameter int BANK_LINES = 32,
   parameter int LEVEL_W    = $clog2(BANK_LINES) + 1
) (
   input  wire logic                           clock,
   input  wire logic                           rst,
   input  wire logic [stc_pkg::ADDR_W-1:0]     host_addr,
   input  wire logic                           host_wr,
   input  wire logic                           host_rd,
   input  wire logic                           host_mem,
   input  wire logic [stc_pkg::DATA_W-1:0]     host_wdata,
   output logic      [stc_pkg::DATA_W-1:0]     host_rdata,
   output logic                                host_rvalid,
   input  wire logic [stc_pkg::PORT_W-1:0]     core_cred_port,
   output logic      [stc_pkg::CREDIT_W-1:0]   core_cred_data,
   input  wire logic                           core_stat_we,
   input  wire logic [stc_pkg::PORT_W-1:0]     core_stat_port,
   input  wire logic [stc_pkg::STATUS_W-1:0]   core_stat_data,
   input  wire logic                           status_sync,
   input  wire logic                           status_sym_valid,
   input  wire logic [1:0]                     status_sym,
   output logic      [7:0]                     main_calendar_repeat_count,
   output logic      [stc_pkg::LEN_W-1:0]      main_calendar_length,
   output logic      [7:0]                     shadow_calendar_repeat_count,
   output logic      [stc_pkg::LEN_W-1:0]      shadow_calendar_length,
   output logic      [7:0]                     bank_virtual_fifo_count,
   output logic      [7:0]                     bank_aggregation_mode,
   output logic      [3:0]                     aggregation_invalid,
   output logic      [4*LEVEL_W-1:0]           bank_full_level,
   output logic      [4*LEVEL_W-1:0]           bank_empty_level,
   output logic                                calendar_select_shadow
);

   // ==========================================================
   // storage
   logic [7:0]                   cal_ctrl;
   logic [7:0]                   internal_memory_access_select;
   logic [7:0]                   buffer_level_type_select;
   logic [stc_pkg::LEN_HI_W-1:0] main_len_high;
   logic [7:0]                   main_len_low;
   logic [stc_pkg::LEN_HI_W-1:0] shadow_len_high;
   logic [7:0]                   shadow_len_low;
   logic [stc_pkg::CREDIT_W-1:0] credit_mem [256];
   logic [stc_pkg::STATUS_W-1:0] status_mem [256];

   // ==========================================================
   // decode
   wire logic       reg_wr      = host_wr && !host_mem;
   wire logic       cred_en     = internal_memory_access_select[stc_pkg::BIT_CRED_SEL];
   wire logic       stat_en     = internal_memory_access_select[stc_pkg::BIT_STAT_SEL];
   wire logic       cred_access = host_mem && cred_en;
   wire logic       stat_access = host_mem && !cred_en && stat_en
                                  && host_addr[8] == 1'b0;
   wire logic [7:0] cred_port   = host_addr[8:1];
   wire logic       cred_hi     = host_addr[0];
   wire logic [7:0] stat_port   = host_addr[7:0];
   wire logic [stc_pkg::CREDIT_W-1:0] cred_word = credit_mem[cred_port];

   wire logic hit_cal_ctrl = host_addr == stc_pkg::OFS_CAL_CTRL;
   wire logic hit_mem_sel  = host_addr == stc_pkg::OFS_MEM_SEL;
   wire logic hit_level    = host_addr == stc_pkg::OFS_LEVEL_SEL;
   wire logic hit_main_rep = host_addr == stc_pkg::OFS_MAIN_REPEAT;
   wire logic hit_main_hi  = host_addr == stc_pkg::OFS_MAIN_LEN_HI;
   wire logic hit_main_lo  = host_addr == stc_pkg::OFS_MAIN_LEN_LO;
   wire logic hit_shd_rep  = host_addr == stc_pkg::OFS_SHD_REPEAT;
   wire logic hit_shd_hi   = host_addr == stc_pkg::OFS_SHD_LEN_HI;
   wire logic hit_shd_lo   = host_addr == stc_pkg::OFS_SHD_LEN_LO;
   wire logic hit_numfifo  = host_addr == stc_pkg::OFS_NUMFIFO;
   wire logic hit_aggr     = host_addr == stc_pkg::OFS_AGGR;

   // ==========================================================
   // read mux
   logic [7:0] next_rdata;
   always_comb
   begin
      next_rdata = 8'h00;
      if (host_mem && cred_access)
      begin
         if (cred_hi)
            next_rdata = {6'h00, cred_word[9:8]};
         else
            next_rdata = cred_word[7:0];
      end
      else if (host_mem && stat_access)
         next_rdata = {6'h00, status_mem[stat_port]};
      else if (host_mem)
         next_rdata = 8'h00;
      else if (hit_cal_ctrl)
         next_rdata = cal_ctrl & 8'h02;
      else if (hit_mem_sel)
         next_rdata = internal_memory_access_select & 8'h03;
      else if (hit_level)
         next_rdata = buffer_level_type_select;
      else if (hit_main_rep)
         next_rdata = main_calendar_repeat_count;
      else if (hit_main_hi)
         next_rdata = {6'h00, main_len_high};
      else if (hit_main_lo)
         next_rdata = main_len_low;
      else if (hit_shd_rep)
         next_rdata = shadow_calendar_repeat_count;
      else if (hit_shd_hi)
         next_rdata = {6'h00, shadow_len_high};
      else if (hit_shd_lo)
         next_rdata = shadow_len_low;
      else if (hit_numfifo)
         next_rdata = bank_virtual_fifo_count;
      else if (hit_aggr)
         next_rdata = bank_aggregation_mode;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         host_rdata  <= stc_pkg::RST_BYTE;
         host_rvalid <= 1'b0;
      end
      else
      begin
         host_rdata  <= host_rd ? next_rdata : stc_pkg::RST_BYTE;
         host_rvalid <= host_rd;
      end
   end

   // ==========================================================
   // configuration registers
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cal_ctrl                      <= stc_pkg::RST_BYTE;
         internal_memory_access_select <= stc_pkg::RST_BYTE;
         buffer_level_type_select      <= stc_pkg::RST_BYTE;
         main_calendar_repeat_count    <= stc_pkg::RST_BYTE;
         shadow_calendar_repeat_count  <= stc_pkg::RST_BYTE;
         bank_virtual_fifo_count       <= stc_pkg::RST_BYTE;
         bank_aggregation_mode         <= stc_pkg::RST_BYTE;
         main_len_high                 <= '0;
         main_len_low                  <= stc_pkg::RST_BYTE;
         shadow_len_high               <= '0;
         shadow_len_low                <= stc_pkg::RST_BYTE;
      end
      else if (reg_wr)
      begin
         if (hit_cal_ctrl)
            cal_ctrl <= host_wdata & 8'h02;
         if (hit_mem_sel)
            internal_memory_access_select <= host_wdata & 8'h03;
         if (hit_level)
            buffer_level_type_select <= host_wdata;
         if (hit_main_rep)
            main_calendar_repeat_count <= host_wdata;
         if (hit_main_hi)
            main_len_high <= host_wdata[1:0];
         if (hit_main_lo)
            main_len_low <= host_wdata;
         if (hit_shd_rep)
            shadow_calendar_repeat_count <= host_wdata;
         if (hit_shd_hi)
            shadow_len_high <= host_wdata[1:0];
         if (hit_shd_lo)
            shadow_len_low <= host_wdata;
         if (hit_numfifo)
            bank_virtual_fifo_count <= host_wdata;
         if (hit_aggr)
            bank_aggregation_mode <= host_wdata;
      end
   end

   // ==========================================================
   // combined lengths, applied on the low byte write
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         main_calendar_length   <= '0;
         shadow_calendar_length <= '0;
      end
      else
      begin
         if (reg_wr && hit_main_lo)
            main_calendar_length <= {main_len_high, host_wdata};
         if (reg_wr && hit_shd_lo)
            shadow_calendar_length <= {shadow_len_high, host_wdata};
      end
   end

   // ==========================================================
   // memories: host writes gated by the selects
   always_ff @(posedge clock)
   begin
      if (host_wr && cred_access && !cred_hi)
         credit_mem[cred_port][7:0] <= host_wdata;
      if (host_wr && cred_access && cred_hi)
         credit_mem[cred_port][9:8] <= host_wdata[1:0];
      if (host_wr && stat_access)
         status_mem[stat_port] <= host_wdata[1:0];
      else if (core_stat_we)
         status_mem[core_stat_port] <= core_stat_data;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         core_cred_data <= '0;
      else
         core_cred_data <= credit_mem[core_cred_port];
   end

   // ==========================================================
   // aggregation code check
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         aggregation_invalid <= '0;
      else
         for (int b = 0; b < stc_pkg::NUM_BANKS; b++)
            aggregation_invalid[b] <= stc_pkg::bank_pair(bank_aggregation_mode, b)
                                      == stc_pkg::AGGR_INVALID;
   end

   // ==========================================================
   // per-bank levels and calendar select detection
   for (genvar g = 0; g < stc_pkg::NUM_BANKS; g++)
   begin : gen_bank
      stc_level_calc #(
         .BANK_LINES (BANK_LINES),
         .LEVEL_W    (LEVEL_W)
      ) u_level (
         .clock           (clock),
         .rst             (rst),
         .fifo_count_code (stc_pkg::bank_pair(bank_virtual_fifo_count, g)),
         .full_sel        (buffer_level_type_select[stc_pkg::FULL_SEL_MSB - g]),
         .empty_sel       (buffer_level_type_select[stc_pkg::EMPTY_SEL_MSB - g]),
         .full_level      (bank_full_level[g*LEVEL_W +: LEVEL_W]),
         .empty_level     (bank_empty_level[g*LEVEL_W +: LEVEL_W])
      );
   end

   stc_cal_detect u_cal (
      .clock         (clock),
      .rst           (rst),
      .detect_enable (cal_ctrl[stc_pkg::BIT_CAL_DETECT]),
      .sync_seen     (status_sync),
      .sym_valid     (status_sym_valid),
      .sym           (status_sym),
      .use_shadow    (calendar_select_shadow)
   );

   // ==========================================================
   // checks
   mem_gate_a: assert property (@(posedge clock) disable iff (rst)
      host_rd && host_mem && internal_memory_access_select[1:0] == 2'h0 |=> host_rdata == 8'h00)
      else $error("memory read without select");

   cred_hi_a: assert property (@(posedge clock) disable iff (rst)
      host_rd && cred_access && cred_hi |=> host_rdata[7:2] == 6'h00)
      else $error("credit high byte not right-justified");

   stat_pad_a: assert property (@(posedge clock) disable iff (rst)
      host_rd && stat_access |=> host_rdata[7:2] == 6'h00)
      else $error("status byte upper bits set");

   main_len_a: assert property (@(posedge clock) disable iff (rst)
      reg_wr && hit_main_lo |=> main_calendar_length == {$past(main_len_high), $past(host_wdata)})
      else $error("main length not combined");

   shd_len_a: assert property (@(posedge clock) disable iff (rst)
      reg_wr && hit_shd_lo |=> shadow_calendar_length == {$past(shadow_len_high), $past(host_wdata)})
      else $error("shadow length not combined");

   len_hold_a: assert property (@(posedge clock) disable iff (rst)
      reg_wr && hit_main_hi |=> $stable(main_calendar_length))
      else $error("main length changed on high write");

   main_rep_a: assert property (@(posedge clock) disable iff (rst)
      reg_wr && hit_main_rep |=> main_calendar_repeat_count == $past(host_wdata))
      else $error("main repeat count not stored");

   shd_rep_a: assert property (@(posedge clock) disable iff (rst)
      reg_wr && hit_shd_rep |=> shadow_calendar_repeat_count == $past(host_wdata))
      else $error("shadow repeat count not stored");

   aggr_bad_a: assert property (@(posedge clock) disable iff (rst)
      bank_aggregation_mode[7:6] == 2'h3 |=> aggregation_invalid[0])
      else $error("invalid aggregation not flagged");

   aggr_last_a: assert property (@(posedge clock) disable iff (rst)
      bank_aggregation_mode[1:0] == 2'h3 |=> aggregation_invalid[3])
      else $error("bank 3 invalid aggregation not flagged");

   cred_lo_wr_a: assert property (@(posedge clock) disable iff (rst)
      host_wr && cred_access && !cred_hi
      |=> credit_mem[$past(cred_port)][7:0] == $past(host_wdata))
      else $error("credit low byte not stored");

   cred_hi_wr_a: assert property (@(posedge clock) disable iff (rst)
      host_wr && cred_access && cred_hi
      |=> credit_mem[$past(cred_port)][9:8] == $past(host_wdata[1:0]))
      else $error("credit high bits not stored");

   stat_wr_a: assert property (@(posedge clock) disable iff (rst)
      host_wr && stat_access |=> status_mem[$past(stat_port)] == $past(host_wdata[1:0]))
      else $error("status entry not stored");

   cred_rd_a: assert property (@(posedge clock) disable iff (rst)
      host_rd && cred_access && !cred_hi |=> host_rdata == $past(cred_word[7:0]))
      else $error("credit low byte misread");

   cred_gate_a: assert property (@(posedge clock) disable iff (rst)
      host_wr && host_mem && internal_memory_access_select[1:0] == 2'h0
      |=> credit_mem[$past(cred_port)] == $past(cred_word))
      else $error("credit written without select");

   memsel_rsv_a: assert property (@(posedge clock) disable iff (rst)
      host_rd && !host_mem && hit_mem_sel |=> host_rdata[7:2] == 6'h00)
      else $error("select register reserved bits set");

   calctl_rsv_a: assert property (@(posedge clock) disable iff (rst)
      host_rd && !host_mem && hit_cal_ctrl |=> host_rdata[7:2] == 6'h00 && !host_rdata[0])
      else $error("calendar control reserved bits set");

   len_rsv_a: assert property (@(posedge clock) disable iff (rst)
      host_rd && !host_mem && (hit_main_hi || hit_shd_hi) |=> host_rdata[7:2] == 6'h00)
      else $error("length high reserved bits set");

endmodule
`default_nettype wire

/* verification/stc_tx_config_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module stc_tx_config_bench;
   localparam int LW = 6;
   logic            clock = 1'b0;
   logic            rst = 1'b1;
   logic [17:0]     host_addr = 18'h0;
   logic            host_wr = 1'b0, host_rd = 1'b0, host_mem = 1'b0, host_rvalid, cal_shd;
   logic            status_sync = 1'b0, status_sym_valid = 1'b0, core_stat_we = 1'b0;
   logic [1:0]      status_sym = 2'h0, core_stat_data = 2'h0;
   logic [7:0]      host_wdata = 8'h0, host_rdata, mrep, srep, nfifo, aggr, rd_val;
   logic [7:0]      core_cred_port = 8'h0, core_stat_port = 8'h0;
   logic [9:0]      core_cred_data, mlen, slen;
   logic [3:0]      agg_bad;
   logic [4*LW-1:0] full_lv, empty_lv;
   int              bad_count = 0;
   int              cmp_count = 0;
   always #10 clock = ~clock;
   stc_tx_config #(.BANK_LINES(32)) i_stc_tx_config (.clock(clock), .rst(rst),
      .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_mem(host_mem),
      .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
      .core_cred_port(core_cred_port), .core_cred_data(core_cred_data),
      .core_stat_we(core_stat_we), .core_stat_port(core_stat_port), .core_stat_data(core_stat_data),
      .status_sync(status_sync), .status_sym_valid(status_sym_valid), .status_sym(status_sym),
      .main_calendar_repeat_count(mrep), .main_calendar_length(mlen),
      .shadow_calendar_repeat_count(srep), .shadow_calendar_length(slen),
      .bank_virtual_fifo_count(nfifo), .bank_aggregation_mode(aggr),
      .aggregation_invalid(agg_bad), .bank_full_level(full_lv), .bank_empty_level(empty_lv),
      .calendar_select_shadow(cal_shd));
   // ==========================================================
   // shared tasks
   task automatic tally_and_finish();
      if (bad_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic acc(input logic [17:0] a, input logic [7:0] d, input logic m, input logic w);
      @(posedge clock);
      #1;
      host_addr = a;
      host_wdata = d;
      host_mem = m;
      host_wr = w;
      host_rd = ~w;
      @(posedge clock);
      #1;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_mem = 1'b0;
      rd_val = host_rdata;
      if (!w)
         chk("rvalid", 16'h1, {15'h0, host_rvalid});
   endtask
   task automatic rdchk(input logic [17:0] a, input logic m, input logic [7:0] exp);
      acc(a, 8'h00, m, 1'b0);
      chk("rdata", {8'h0, exp}, {8'h0, rd_val});
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      logic [17:0] ofs [11] = '{stc_pkg::OFS_CAL_CTRL, stc_pkg::OFS_MEM_SEL,
         stc_pkg::OFS_LEVEL_SEL, stc_pkg::OFS_MAIN_REPEAT, stc_pkg::OFS_MAIN_LEN_HI,
         stc_pkg::OFS_MAIN_LEN_LO, stc_pkg::OFS_SHD_REPEAT, stc_pkg::OFS_SHD_LEN_HI,
         stc_pkg::OFS_SHD_LEN_LO, stc_pkg::OFS_NUMFIFO, stc_pkg::OFS_AGGR};
      foreach (ofs[i])
         rdchk(ofs[i], 1'b0, 8'h00);
      acc(18'h30918, 8'hff, 1'b0, 1'b1);
      rdchk(18'h30918, 1'b0, 8'h00);
   endtask
   task automatic t_counts();
      acc(stc_pkg::OFS_MAIN_REPEAT, 8'ha5, 1'b0, 1'b1);
      acc(stc_pkg::OFS_SHD_REPEAT, 8'h5a, 1'b0, 1'b1);
      chk("main repeat", 16'h00a5, {8'h0, mrep});
      chk("shadow repeat", 16'h005a, {8'h0, srep});
      rdchk(stc_pkg::OFS_MAIN_REPEAT, 1'b0, 8'ha5);
      rdchk(stc_pkg::OFS_SHD_REPEAT, 1'b0, 8'h5a);
   endtask
   task automatic t_length();
      acc(stc_pkg::OFS_MAIN_LEN_HI, 8'hff, 1'b0, 1'b1);
      acc(stc_pkg::OFS_SHD_LEN_HI, 8'h42, 1'b0, 1'b1);
      rdchk(stc_pkg::OFS_MAIN_LEN_HI, 1'b0, 8'h03);
      chk("main len staged", 16'h0, {6'h0, mlen});
      acc(stc_pkg::OFS_MAIN_LEN_LO, 8'h3c, 1'b0, 1'b1);
      acc(stc_pkg::OFS_SHD_LEN_LO, 8'hc3, 1'b0, 1'b1);
      @(posedge clock);
      #1;
      chk("main len", 16'h033c, {6'h0, mlen});
      chk("shadow len", 16'h02c3, {6'h0, slen});
   endtask
   task automatic levels(input logic [7:0] sel, input int f [4], input int e [4]);
      acc(stc_pkg::OFS_LEVEL_SEL, sel, 1'b0, 1'b1);
      repeat (2) @(posedge clock);
      #1;
      for (int b = 0; b < 4; b++)
      begin
         chk("full level", 16'(f[b]), {10'h0, full_lv[b*LW +: LW]});
         chk("empty level", 16'(e[b]), {10'h0, empty_lv[b*LW +: LW]});
      end
   endtask
   task automatic t_banks();
      acc(stc_pkg::OFS_NUMFIFO, 8'h1b, 1'b0, 1'b1);
      acc(stc_pkg::OFS_AGGR, 8'he4, 1'b0, 1'b1);
      levels(8'hf0, '{25, 13, 7, 4}, '{0, 0, 0, 0});
      levels(8'h0f, '{32, 16, 8, 4}, '{7, 3, 1, 0});
      chk("aggr", 16'h00e4, {8'h0, aggr});
      chk("aggr invalid", 16'h0001, {12'h0, agg_bad});
      rdchk(stc_pkg::OFS_NUMFIFO, 1'b0, 8'h1b);
      chk("numfifo", 16'h001b, {8'h0, nfifo});
      acc(stc_pkg::OFS_AGGR, 8'h1b, 1'b0, 1'b1);
      @(posedge clock);
      #1;
      chk("aggr invalid", 16'h0008, {12'h0, agg_bad});
   endtask
   task automatic t_mem();
      acc(stc_pkg::OFS_MEM_SEL, 8'h02, 1'b0, 1'b1);
      acc(18'h000a4, 8'ha5, 1'b1, 1'b1);
      acc(18'h000a5, 8'hff, 1'b1, 1'b1);
      rdchk(18'h000a5, 1'b1, 8'h03);
      rdchk(18'h000a4, 1'b1, 8'ha5);
      core_cred_port = 8'h52;
      repeat (2) @(posedge clock);
      #1;
      chk("core credit", 16'h03a5, {6'h0, core_cred_data});
      acc(stc_pkg::OFS_MEM_SEL, 8'h01, 1'b0, 1'b1);
      acc(18'h00033, 8'hff, 1'b1, 1'b1);
      rdchk(18'h00033, 1'b1, 8'h03);
      acc(stc_pkg::OFS_MEM_SEL, 8'h00, 1'b0, 1'b1);
      acc(18'h000a4, 8'h11, 1'b1, 1'b1);
      rdchk(18'h00033, 1'b1, 8'h00);
      rdchk(18'h000a4, 1'b1, 8'h00);
      acc(stc_pkg::OFS_MEM_SEL, 8'h03, 1'b0, 1'b1);
      rdchk(18'h000a4, 1'b1, 8'ha5);
      rdchk(18'h000a5, 1'b1, 8'h03);
      acc(stc_pkg::OFS_MEM_SEL, 8'h01, 1'b0, 1'b1);
      acc(18'h00133, 8'h00, 1'b1, 1'b1);
      rdchk(18'h00133, 1'b1, 8'h00);
      rdchk(18'h00033, 1'b1, 8'h03);
      @(posedge clock);
      #1;
      core_stat_we = 1'b1;
      core_stat_port = 8'h40;
      core_stat_data = 2'h2;
      @(posedge clock);
      #1;
      core_stat_we = 1'b0;
      rdchk(18'h00040, 1'b1, 8'h02);
   endtask
   task automatic cal_word(input logic [1:0] s, input logic exp);
      @(posedge clock);
      #1;
      status_sync = 1'b1;
      @(posedge clock);
      #1;
      status_sync = 1'b0;
      status_sym_valid = 1'b1;
      status_sym = s;
      @(posedge clock);
      #1;
      status_sym_valid = 1'b0;
      @(posedge clock);
      #1;
      chk("calendar select", {15'h0, exp}, {15'h0, cal_shd});
   endtask
   task automatic t_cal();
      cal_word(2'h2, 1'b0);
      acc(stc_pkg::OFS_CAL_CTRL, 8'h02, 1'b0, 1'b1);
      cal_word(2'h2, 1'b1);
      cal_word(2'h3, 1'b1);
      cal_word(2'h1, 1'b0);
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial
   begin
      repeat (5) @(posedge clock);
      #1;
      rst = 1'b0;
      t_reset();
      t_counts();
      t_length();
      t_banks();
      t_mem();
      t_cal();
      tally_and_finish();
   end
   initial
   begin
      #200000;
      bad_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
